// file: hw/usb_upstream_sie_config.sv
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "usb_sie_map.svh"
module usb_upstream_sie_config
  import usb_sie_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // upstream pins
  input wire logic usb_dp_in,
  input wire logic usb_dm_in,
  output logic usb_dp_out,
  output logic usb_dp_oe,
  output logic usb_dm_out,
  output logic usb_dm_oe,
  // engine transmit drive
  input wire logic sie_dp_out,
  input wire logic sie_dm_out,
  input wire logic sie_oe,
  // token address match
  input wire logic [6:0] tok_addr,
  output logic fn_a_match,
  output logic fn_b_match,
  // endpoint 0 updates from the engine
  input wire logic ep0_upd,
  input wire logic ep0_upd_fn_b,
  input wire tok_t ep0_upd_tok,
  input wire logic ep0_upd_ack,
  input wire logic setup_force_a,
  input wire logic setup_force_b,
  output logic fifo_wr_block_a,
  output logic fifo_wr_block_b,
  // FIFO placement lookup
  input wire logic ep_fn_b,
  input wire logic [2:0] ep_num,
  output logic [7:0] fifo_base,
  output logic fifo_big,
  output logic two_addr,
  output logic [4:0] ep_dir_in,
  // FIFO write bus steal
  input wire logic fifo_byte_wr,
  output logic cpu_stall,
  // frame timing
  input wire logic frame_eof1,
  output logic hub_eop
);

  logic [7:0] addr_a_r;
  logic [7:0] addr_b_r;
  logic [7:0] ep0_a_r;
  logic [7:0] ep0_b_r;
  logic [7:0] ep0_a_nxt;
  logic [7:0] ep0_b_nxt;
  logic [2:0] force_r;
  logic act_r;
  logic size_r;
  logic single_r;
  logic [4:0] ep_dir_r;
  logic lock_a_r;
  logic lock_b_r;
  logic wr_pend_r;
  logic [7:0] wr_idx_r;
  logic [31:0] hrdata_r;
  logic [2:0] dp_sync_r;
  logic [2:0] dm_sync_r;
  logic dp_st_r;
  logic dm_st_r;
  logic [2:0] sync_fill_r;
  logic [4:0] stall_cnt_r;
  logic hub_eop_r;
  logic acc;
  logic rd_acc;
  logic [7:0] rd_idx;
  logic wr_stat;
  logic non_idle;
  logic [7:0] st_val;

  // bus slave answers every transfer with zero wait states
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign acc = hsel & htrans[1] & hready;
  assign rd_acc = acc & ~hwrite;
  assign rd_idx = haddr[9:2];
  assign wr_stat = wr_pend_r & (wr_idx_r == `IDX_STATUS);

  // address phase capture for the write data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
    end else begin
      wr_pend_r <= acc & hwrite;
      wr_idx_r <= rd_idx;
    end
  end

  assign st_val = {size_r, single_r, dp_st_r, dm_st_r, act_r, force_r};

  // read data registered at the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_acc) begin
      case (rd_idx)
        `IDX_FN_A_ADDR: hrdata_r <= {24'h00_0000, addr_a_r};
        `IDX_FN_A_EP0: hrdata_r <= {24'h00_0000, ep0_a_r};
        `IDX_STATUS: hrdata_r <= {24'h00_0000, st_val};
        `IDX_FN_B_ADDR: hrdata_r <= {24'h00_0000, addr_b_r};
        `IDX_FN_B_EP0: hrdata_r <= {24'h00_0000, ep0_b_r};
        `IDX_EP_DIR: hrdata_r <= {27'h000_0000, ep_dir_r};
        default: hrdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_sync_r <= 3'h0;
      dm_sync_r <= 3'h0;
      dp_st_r <= 1'b0;
      dm_st_r <= 1'b0;
      sync_fill_r <= 3'h0;
    end else begin
      if (sync_fill_r != `SYNC_FILL) begin
        sync_fill_r <= sync_fill_r + 3'h1;
      end
      dp_sync_r <= {dp_sync_r[1:0], usb_dp_in};
      dm_sync_r <= {dm_sync_r[1:0], usb_dm_in};
      if (dp_sync_r[1] == dp_sync_r[2]) begin
        dp_st_r <= dp_sync_r[2];
      end
      if (dm_sync_r[1] == dm_sync_r[2]) begin
        dm_st_r <= dm_sync_r[2];
      end
    end
  end

  // anything other than the J idle state counts as bus activity
  // the stages reset low, which looks like SE0; wait for real samples or the
  // flag would be set by reset itself
  assign non_idle = (sync_fill_r == `SYNC_FILL) & ~(dp_st_r & ~dm_st_r);

  // status/control: force code, layout bits and the sticky activity flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      force_r <= 3'h0;
      size_r <= 1'b0;
      single_r <= 1'b0;
      act_r <= 1'b0;
    end else begin
      if (wr_stat) begin
        force_r <= hwdata[2:0];
        size_r <= hwdata[`ST_SIZE];
        single_r <= hwdata[`ST_MODE];
      end
      // set wins over a clearing write in the same cycle
      if (non_idle) begin
        act_r <= 1'b1;
      end else if (wr_stat && !hwdata[`ST_ACT]) begin
        act_r <= 1'b0;
      end
    end
  end

  // upstream drivers; a nonzero code overrides the engine
  always_comb begin
    usb_dp_out = 1'b0;
    usb_dm_out = 1'b0;
    usb_dp_oe = 1'b1;
    usb_dm_oe = 1'b1;
    case (force_r)
      FRC_NONE: begin
        usb_dp_out = sie_dp_out;
        usb_dm_out = sie_dm_out;
        usb_dp_oe = sie_oe;
        usb_dm_oe = sie_oe;
      end
      FRC_J: usb_dp_out = 1'b1;
      FRC_K: usb_dm_out = 1'b1;
      FRC_SE0, FRC_LOW: usb_dp_oe = 1'b1;
      FRC_DP_Z: usb_dp_oe = 1'b0;
      FRC_DM_Z: usb_dm_oe = 1'b0;
      FRC_ALL_Z: begin
        usb_dp_oe = 1'b0;
        usb_dm_oe = 1'b0;
      end
      default: usb_dp_oe = 1'b1;
    endcase
  end

  // device address registers and own endpoint direction register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_a_r <= `REG_RESET;
      addr_b_r <= `REG_RESET;
      ep_dir_r <= 5'h00;
    end else if (wr_pend_r) begin
      if (wr_idx_r == `IDX_FN_A_ADDR) begin
        addr_a_r <= hwdata[7:0];
      end
      if (wr_idx_r == `IDX_FN_B_ADDR) begin
        addr_b_r <= hwdata[7:0];
      end
      if (wr_idx_r == `IDX_EP_DIR) begin
        ep_dir_r <= hwdata[4:0];
      end
    end
  end

  // a disabled address never matches, address zero included
  assign fn_a_match = addr_a_r[`ADDR_EN] & (tok_addr == addr_a_r[6:0]);
  assign fn_b_match = addr_b_r[`ADDR_EN] & ~single_r & (tok_addr == addr_b_r[6:0]);
  assign two_addr = ~single_r;
  assign ep_dir_in = ep_dir_r;

  // next endpoint 0 mode value; ctrl low gives the plain endpoint 3 format
  function automatic logic [7:0] ep0_next(
    input logic [7:0] cur,
    input logic wr,
    input logic [7:0] wdata,
    input logic locked,
    input logic upd,
    input tok_t tok,
    input logic ack,
    input logic frc,
    input logic ctrl
  );
    logic [7:0] v;
    v = cur;
    if (wr && !ctrl) begin
      v = wdata;
    end else if (wr) begin
      v[`EP0_SETUP] = 1'b0;
      if (!locked) begin
        v[6:0] = wdata[6:0];
      end
    end
    if (upd && ctrl) begin
      case (tok)
        TOK_SETUP: v[`EP0_SETUP] = 1'b1;
        TOK_IN: v[`EP0_IN] = 1'b1;
        TOK_OUT: v[`EP0_OUT] = 1'b1;
        default: v[`EP0_OUT] = v[`EP0_OUT];
      endcase
    end
    if (upd && ack) begin
      v[`EP0_ACK] = 1'b1;
    end
    if (frc && ctrl) begin
      v[`EP0_SETUP] = 1'b1;
    end
    return v;
  endfunction : ep0_next

  always_comb begin
    ep0_a_nxt = ep0_next(ep0_a_r, wr_pend_r && wr_idx_r == `IDX_FN_A_EP0, hwdata[7:0],
                         lock_a_r, ep0_upd && !ep0_upd_fn_b, ep0_upd_tok, ep0_upd_ack,
                         setup_force_a, 1'b1);
    ep0_b_nxt = ep0_next(ep0_b_r, wr_pend_r && wr_idx_r == `IDX_FN_B_EP0, hwdata[7:0],
                         lock_b_r, ep0_upd && ep0_upd_fn_b, ep0_upd_tok, ep0_upd_ack,
                         setup_force_b, ~single_r);
  end

  // endpoint 0 mode registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ep0_a_r <= `REG_RESET;
      ep0_b_r <= `REG_RESET;
    end else begin
      ep0_a_r <= ep0_a_nxt;
      ep0_b_r <= ep0_b_nxt;
    end
  end

  // write lock: engine update sets it, a read of that register clears it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_a_r <= 1'b0;
      lock_b_r <= 1'b0;
    end else begin
      if (ep0_upd && !ep0_upd_fn_b) begin
        lock_a_r <= 1'b1;
      end else if (rd_acc && rd_idx == `IDX_FN_A_EP0) begin
        lock_a_r <= 1'b0;
      end
      if (ep0_upd && ep0_upd_fn_b && !single_r) begin
        lock_b_r <= 1'b1;
      end else if (rd_acc && rd_idx == `IDX_FN_B_EP0) begin
        lock_b_r <= 1'b0;
      end
    end
  end

  // firmware may not overwrite setup data still waiting to be read
  assign fifo_wr_block_a = ep0_a_r[`EP0_SETUP];
  assign fifo_wr_block_b = ep0_b_r[`EP0_SETUP] & ~single_r;

  // FIFO base lookup; single mode moves A3/A4 into the B slots
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fifo_base <= `B_SM_A0;
      fifo_big <= 1'b0;
    end else begin
      fifo_big <= size_r & ~ep_fn_b & (ep_num == 3'd1 || ep_num == 3'd2);
      if (ep_fn_b || (single_r && ep_num >= 3'd3)) begin
        // A3 takes the B0 slot, A4 the B1 slot
        if ((ep_fn_b && ep_num == 3'd0) || (!ep_fn_b && ep_num == 3'd3)) begin
          fifo_base <= size_r ? `B_LG_B0 : `B_SM_B0;
        end else begin
          fifo_base <= size_r ? `B_LG_B1 : `B_SM_B1;
        end
      end else begin
        case (ep_num)
          3'd1: fifo_base <= size_r ? `B_LG_A1 : `B_SM_A1;
          3'd2: fifo_base <= size_r ? `B_LG_A2 : `B_SM_A2;
          default: fifo_base <= size_r ? `B_LG_A0 : `B_SM_A0;
        endcase
      end
    end
  end

  // each engine byte into user RAM steals the data bus for three cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stall_cnt_r <= 5'd0;
    end else begin
      stall_cnt_r <= stall_cnt_r - {4'd0, (stall_cnt_r != 5'd0)}
                     + (fifo_byte_wr ? `STALL_PER_BYTE : 5'd0);
    end
  end
  assign cpu_stall = (stall_cnt_r != 5'd0);

  // end of packet issued by the hub repeater at EOF1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hub_eop_r <= 1'b0;
    end else begin
      hub_eop_r <= frame_eof1;
    end
  end
  assign hub_eop = hub_eop_r;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_FORCE_OFF: assert property (force_r == FRC_NONE |->
    usb_dp_out == sie_dp_out && usb_dm_oe == sie_oe) else $error("engine not driving");
  AST_FORCE_J: assert property (force_r == FRC_J |->
    usb_dp_oe && usb_dm_oe && usb_dp_out && !usb_dm_out) else $error("force J wrong");
  AST_FORCE_SE0: assert property (force_r inside {FRC_SE0, FRC_LOW} |->
    usb_dp_oe && usb_dm_oe && !usb_dp_out && !usb_dm_out) else $error("force low wrong");
  AST_FORCE_Z: assert property (force_r == FRC_DP_Z |->
    !usb_dp_oe && usb_dm_oe && !usb_dm_out) else $error("force float wrong");

  sequence s_keep_wr;
    wr_stat && hwdata[`ST_ACT] && !non_idle;
  endsequence
  AST_ACT_SET: assert property (non_idle |=> act_r) else $error("activity not set");
  AST_ACT_KEEP: assert property (s_keep_wr |=> act_r == $past(act_r))
    else $error("activity changed by write of one");

  AST_PIN_READ: assert property (rd_acc && rd_idx == `IDX_STATUS |=>
    hrdata[5:4] == $past({dp_st_r, dm_st_r})) else $error("pin readback wrong");
  AST_ADDR_EN: assert property (!addr_a_r[`ADDR_EN] |-> !fn_a_match)
    else $error("disabled address matched");

  sequence s_locked_wr;
    lock_a_r && wr_pend_r && wr_idx_r == `IDX_FN_A_EP0 && !ep0_upd;
  endsequence
  AST_LOCK: assert property (s_locked_wr |=> ep0_a_r[6:0] == $past(ep0_a_r[6:0]))
    else $error("locked bits written");
  AST_STALL: assert property (fifo_byte_wr && !cpu_stall |=> cpu_stall [*3])
    else $error("stall too short");
  AST_FIFO_A0: assert property (!size_r && !ep_fn_b && ep_num == 3'd0 |=>
    fifo_base == `B_SM_A0 || $past(size_r) != size_r) else $error("A0 base wrong");

endmodule : usb_upstream_sie_config

// file: hw/usb_sie_map.svh
`ifndef USB_SIE_MAP_SVH
`define USB_SIE_MAP_SVH
// register indices; byte address is four times the index
`define IDX_FN_A_ADDR 8'h10
`define IDX_FN_A_EP0 8'h12
`define IDX_STATUS 8'h1F
`define IDX_FN_B_ADDR 8'h40
`define IDX_FN_B_EP0 8'h42
`define IDX_EP_DIR 8'h20
// status register fields
`define ST_SIZE 7
`define ST_MODE 6
`define ST_DP 5
`define ST_DM 4
`define ST_ACT 3
// endpoint 0 mode register fields
`define EP0_SETUP 7
`define EP0_IN 6
`define EP0_OUT 5
`define EP0_ACK 4
`define ADDR_EN 7
`define REG_RESET 8'h00
// FIFO bases
`define B_SM_B1 8'hD8
`define B_SM_B0 8'hE0
`define B_SM_A2 8'hE8
`define B_SM_A1 8'hF0
`define B_SM_A0 8'hF8
`define B_LG_B0 8'hA8
`define B_LG_B1 8'hB0
`define B_LG_A0 8'hB8
`define B_LG_A1 8'hC0
`define B_LG_A2 8'hE0
`define STALL_PER_BYTE 5'd3
// edges after reset before the synchronised pin levels are real samples
`define SYNC_FILL 3'h4
`endif

// file: hw/usb_sie_pkg.sv
package usb_sie_pkg;
  typedef enum logic [1:0] {
    TOK_SETUP = 2'h0,
    TOK_IN = 2'h1,
    TOK_OUT = 2'h3
  } tok_t;
  typedef enum logic [2:0] {
    FRC_NONE = 3'h0,
    FRC_J = 3'h1,
    FRC_K = 3'h2,
    FRC_SE0 = 3'h3,
    FRC_LOW = 3'h4,
    FRC_DP_Z = 3'h5,
    FRC_DM_Z = 3'h6,
    FRC_ALL_Z = 3'h7
  } force_t;
endpackage : usb_sie_pkg

// file: dv/usb_host_model.sv
`timescale 1ns/1ps
// upstream host end: the device pull-up idles the pair at J, the host drives K on demand
module usb_host_model (
  input wire logic dp_out,
  input wire logic dp_oe,
  input wire logic dm_out,
  input wire logic dm_oe,
  input wire logic send_k,
  output logic dp,
  output logic dm
);
  // device drive wins; a released line takes its pull level, or K while send_k is high, never the last value
  assign dp = dp_oe ? dp_out : !send_k;
  assign dm = dm_oe ? dm_out : send_k;
endmodule : usb_host_model

// file: dv/usb_upstream_sie_config_tb_top.sv
`timescale 1ns/1ps
`include "usb_sie_map.svh"
module usb_upstream_sie_config_tb_top;
  import usb_sie_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, seed, d;
  logic [1:0] htrans;
  logic [2:0] hsize, c, num;
  logic dp, dm, dpo, dpe, dmo, dme, sdp, sdm, soe, sk, ma, mb, upd, updb, ack;
  logic blka, blkb, fnb, big, two, fbw, stall, eof1, eop, sfa, sfb;
  logic [6:0] tok_addr, a;
  logic [7:0] base;
  logic [4:0] dir;
  tok_t tok;
  int num_errors, total_checks, i, k, m, n, b;
  logic [7:0] sm [5] = '{8'hF8, 8'hF0, 8'hE8, 8'hE0, 8'hD8};
  logic [7:0] lg [5] = '{8'hB8, 8'hC0, 8'hE0, 8'hA8, 8'hB0};
  logic [7:0] rl [4] = '{`IDX_FN_A_ADDR, `IDX_FN_A_EP0, `IDX_FN_B_ADDR, `IDX_FN_B_EP0};

  usb_upstream_sie_config i_usb_upstream_sie_config (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .usb_dp_in(dp), .usb_dm_in(dm), .usb_dp_out(dpo), .usb_dp_oe(dpe),
    .usb_dm_out(dmo), .usb_dm_oe(dme), .sie_dp_out(sdp), .sie_dm_out(sdm), .sie_oe(soe),
    .tok_addr(tok_addr), .fn_a_match(ma), .fn_b_match(mb), .ep0_upd(upd),
    .ep0_upd_fn_b(updb), .ep0_upd_tok(tok), .ep0_upd_ack(ack), .setup_force_a(sfa),
    .setup_force_b(sfb), .fifo_wr_block_a(blka), .fifo_wr_block_b(blkb), .ep_fn_b(fnb),
    .ep_num(num), .fifo_base(base), .fifo_big(big), .two_addr(two), .ep_dir_in(dir),
    .fifo_byte_wr(fbw), .cpu_stall(stall), .frame_eof1(eof1), .hub_eop(eop));
  usb_host_model i_usb_host_model (.dp_out(dpo), .dp_oe(dpe), .dm_out(dmo), .dm_oe(dme),
    .send_k(sk), .dp(dp), .dm(dm));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // expected {dp level, dp oe, dm level, dm oe}; a floating line's level is masked
  function automatic logic [3:0] fexp(logic [2:0] code);
    case (code)
      3'h0: return {sdp & soe, soe, sdm & soe, soe};
      3'h1: return 4'hD;
      3'h2: return 4'h7;
      3'h5: return 4'h1;
      3'h6: return 4'h4;
      3'h7: return 4'h0;
      default: return 4'h5;
    endcase
  endfunction : fexp

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk

  // bounded wait for hready at a rising edge
  task automatic rdy();
    int cnt;
    cnt = 0;
    do begin
      @(posedge hclk);
      cnt++;
    end while (hreadyout !== 1'b1 && cnt < 50);
    if (hreadyout !== 1'b1) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : rdy

  // one single word transfer; read data captured at the data phase edge
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask : xfer

  task automatic ep0_event(input logic fb, input tok_t t, input logic ak);
    @(posedge hclk);
    upd <= 1'b1;
    updb <= fb;
    tok <= t;
    ack <= ak;
    @(posedge hclk);
    upd <= 1'b0;
  endtask : ep0_event

  initial begin
    seed = 32'd92456;
    {hsel, hwrite, sdp, sdm, soe, upd, updb, ack, fnb, fbw, eof1, sk, sfa, sfb} = '0;
    haddr = '0;
    hwdata = '0;
    htrans = 2'h0;
    hsize = 3'h2;
    tok_addr = '0;
    tok = TOK_SETUP;
    num = '0;
    num_errors = 0;
    total_checks = 0;
    hresetn = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 0; i < 4; i++) begin
      xfer(1'b0, rl[i], 32'h0);
      chk(rd, 32'h0);
      chk(hresp, 32'h0);
    end
    // every force code twice, random engine drive behind it
    for (i = 0; i < 16; i++) begin
      c = i[2:0];
      {sdp, sdm, soe} <= 3'(rnd());
      xfer(1'b1, `IDX_STATUS, {29'h0, c});
      #1 chk({dpo & dpe, dpe, dmo & dme, dme}, fexp(c));
    end
    soe = 1'b0;
    xfer(1'b1, `IDX_STATUS, 32'h0);
    repeat (6) @(posedge hclk);
    xfer(1'b1, `IDX_STATUS, 32'h0);
    xfer(1'b0, `IDX_STATUS, 32'h0);
    chk(rd, 32'h20);
    sk <= 1'b1;
    repeat (6) @(posedge hclk);
    xfer(1'b0, `IDX_STATUS, 32'h0);
    chk(rd, 32'h18);
    sk <= 1'b0;
    repeat (6) @(posedge hclk);
    xfer(1'b1, `IDX_STATUS, 32'h08);
    xfer(1'b0, `IDX_STATUS, 32'h0);
    chk(rd, 32'h28);
    xfer(1'b1, `IDX_STATUS, 32'h0);
    xfer(1'b0, `IDX_STATUS, 32'h0);
    chk(rd, 32'h20);
    // address answered only once enabled
    for (i = 0; i < 2; i++) begin
      a = 7'(rnd() % 127 + 1);
      tok_addr <= a;
      xfer(1'b1, i ? `IDX_FN_B_ADDR : `IDX_FN_A_ADDR, {25'h0, a});
      #1 chk(i ? mb : ma, 32'h0);
      xfer(1'b1, i ? `IDX_FN_B_ADDR : `IDX_FN_A_ADDR, {24'h0, 1'b1, a});
      #1 chk(i ? mb : ma, 32'h1);
      xfer(1'b0, i ? `IDX_FN_B_ADDR : `IDX_FN_A_ADDR, 32'h0);
      chk(rd, {24'h0, 1'b1, a});
      tok_addr <= a ^ 7'h01;
      @(posedge hclk);
      #1 chk(i ? mb : ma, 32'h0);
    end
    d = rnd();
    xfer(1'b1, `IDX_EP_DIR, {27'h0, d[4:0]});
    #1 chk(dir, d[4:0]);
    // FIFO placement in all four size and address layouts
    for (m = 0; m < 4; m++) begin
      xfer(1'b1, `IDX_STATUS, {24'h0, m[1], m[0], 6'h0});
      for (k = 0; k < 5; k++) begin
        @(posedge hclk);
        fnb <= !m[0] && k > 2;
        num <= 3'((!m[0] && k > 2) ? k - 3 : k);
        @(posedge hclk);
        #1 chk({two, big, base}, {!m[0], m[1] && (k == 1 || k == 2), m[1] ? lg[k] : sm[k]});
      end
    end
    xfer(1'b1, `IDX_STATUS, 32'h0);
    // one byte then two back-to-back bytes of bus steal
    // stall cycles count from the edge that takes the first byte
    for (b = 1; b < 3; b++) begin
      @(posedge hclk);
      fbw <= 1'b1;
      n = 0;
      for (k = 0; k < 12; k++) begin
        @(posedge hclk);
        if (k == b - 1) fbw <= 1'b0;
        #1 n += stall;
      end
      chk(n, 3 * b);
    end
    @(posedge hclk);
    eof1 <= 1'b1;
    @(posedge hclk);
    eof1 <= 1'b0;
    #1 chk(eop, 32'h1);
    @(posedge hclk);
    #1 chk(eop, 32'h0);
    // endpoint 0 lock: write before the unlocking read is dropped
    ep0_event(1'b0, TOK_IN, 1'b0);
    xfer(1'b1, `IDX_FN_A_EP0, 32'h05);
    xfer(1'b0, `IDX_FN_A_EP0, 32'h0);
    chk(rd, 32'h40);
    xfer(1'b1, `IDX_FN_A_EP0, 32'h05);
    xfer(1'b0, `IDX_FN_A_EP0, 32'h0);
    chk(rd, 32'h05);
    ep0_event(1'b0, TOK_SETUP, 1'b1);
    @(posedge hclk);
    #1 chk(blka, 32'h1);
    xfer(1'b1, `IDX_FN_A_EP0, 32'h0);
    xfer(1'b0, `IDX_FN_A_EP0, 32'h0);
    chk(rd, 32'h15);
    #1 chk(blka, 32'h0);
    // setup data phase holds the SETUP flag up over a clearing write
    sfa <= 1'b1;
    xfer(1'b1, `IDX_FN_A_EP0, 32'h0);
    xfer(1'b0, `IDX_FN_A_EP0, 32'h0);
    chk(rd, 32'h80);
    sfa <= 1'b0;
    ep0_event(1'b1, TOK_OUT, 1'b0);
    xfer(1'b0, `IDX_FN_B_EP0, 32'h0);
    chk(rd, 32'h20);
    ep0_event(1'b1, TOK_SETUP, 1'b0);
    @(posedge hclk);
    #1 chk(blkb, 32'h1);
    // single address: the second endpoint 0 register becomes plain storage
    xfer(1'b1, `IDX_STATUS, 32'h40);
    #1 chk(blkb, 32'h0);
    sfb <= 1'b1;
    ep0_event(1'b1, TOK_IN, 1'b0);
    xfer(1'b1, `IDX_FN_B_EP0, 32'h5A);
    xfer(1'b0, `IDX_FN_B_EP0, 32'h0);
    chk(rd, 32'h5A);
    sfb <= 1'b0;
    tally_and_finish();
  end
endmodule : usb_upstream_sie_config_tb_top
